// ### include/adc_regs_params.svh
// Purpose: Offsets, field positions, reset words and constants of the range/status bank
// Assumes: Register index is the word index; byte address is four times the index
// Notes:   Definitions only
`ifndef ADC_REGS_PARAMS_SVH
`define ADC_REGS_PARAMS_SVH

// Register indexes (byte address = index * 4)
`define IDX_CONFIG         6'h02
`define IDX_A_RANGE_LOW    6'h04
`define IDX_A_RANGE_HIGH   6'h05
`define IDX_B_RANGE_LOW    6'h06
`define IDX_B_RANGE_HIGH   6'h07
`define IDX_STATUS         6'h08
`define IDX_A_OVERRANGE    6'h0A
`define IDX_B_OVERRANGE    6'h0B

// Word layout
`define DIR_BIT            15
`define SEL_HI             14
`define SEL_LO             9
`define RSVD_BIT           8
`define FIELD_HI           7
`define STATUS_APPEND_BIT  1

// Reset words
`define RST_CONFIG         16'h0400
`define RST_A_RANGE_LOW    16'h08FF
`define RST_A_RANGE_HIGH   16'h0AFF
`define RST_B_RANGE_LOW    16'h0CFF
`define RST_B_RANGE_HIGH   16'h0EFF
`define RST_STATUS         16'h0000
`define RST_A_OVERRANGE    16'h1400
`define RST_B_OVERRANGE    16'h1600

// Bus decode
`define BUS_ADDR_LSB       2
`define BUS_ADDR_HI_ZERO   24'h000000
`define BUS_SIZE_WORD      3'h2

// Full-scale spans in millivolts
`define SPAN_10V_MV        16'h2710
`define SPAN_5V_MV         16'h1388
`define SPAN_2V5_MV        16'h09C4
`define OVERRANGE_DIV      16'h0005

// Output data check and test pattern
`define CRC8_POLY          8'h07
`define CRC8_INIT          8'h00
`define TEST_PATTERN_A     16'hAAAA
`define TEST_PATTERN_B     16'h5555

`endif

// ### include/adc_regs_pkg.sv
// Purpose: Types shared by the range/status register bank
// Assumes: Constants live in adc_regs_params.svh
// Notes:   One-hot bus states
package adc_regs_pkg;

   typedef logic [5:0] reg_idx_t;

   typedef enum logic [1:0] {
      BUS_IDLE = 2'b01,
      BUS_WAIT = 2'b10
   } bus_state_e;

   typedef enum logic [1:0] {
      SPAN_10V_ALT = 2'b00,
      SPAN_2V5     = 2'b01,
      SPAN_5V      = 2'b10,
      SPAN_10V     = 2'b11
   } span_code_e;

   typedef enum logic [3:0] {
      CH_INPUT0       = 4'h0,
      CH_INPUT1       = 4'h1,
      CH_INPUT2       = 4'h2,
      CH_INPUT3       = 4'h3,
      CH_INPUT4       = 4'h4,
      CH_INPUT5       = 4'h5,
      CH_INPUT6       = 4'h6,
      CH_INPUT7       = 4'h7,
      CH_SUPPLY       = 4'h8,
      CH_REGULATOR    = 4'h9,
      CH_TEST_PATTERN = 4'hB
   } chan_code_e;

endpackage : adc_regs_pkg

// ### rtl/adc_range_status_regs.sv
// Purpose: Range, over-range and conversion status register bank on AHB-Lite
// Assumes: Converter side presents conv_valid pulses with indices and data
// Notes:   Each register word except status carries direction, its own select and a reserved bit
// Operation
// - Bit 15 of a word is the direction: 0 asks a read, 1 asks a write.
// - Bits 14 to 9 carry the six-bit select naming the register accessed.
// - Bit 8 of range, over-range and config words is reserved and reads zero.
// - Word 0x6 holds B channels 3..0 spans in bits 7-6..1-0, reset 0xCFF.
// - Word 0x7 holds B channels 7..4 spans in bits 7-6..1-0, reset 0xEFF.
// - Span code 00 and 11 mean 10 V, 01 means 2.5 V, 10 means 5 V; reset 11.
// - Status bits 15-12 show the last A channel converted; status resets to 0.
// - Status bits 11-8 show the last B channel converted.
// - Status bits 7-0 hold the read-only 8-bit CRC of the output data.
// - Word 0xA bit n widens A channel n span by 20 percent; reset 0x1400.
// - Word 0xB bit n widens B channel n span by 20 percent; reset 0x1600.
// - B over-range bits 0-3 act on word 0x06 spans, bits 4-7 on word 0x07.
// - A over-range bits 0-3 act on word 0x04 spans, bits 4-7 on word 0x05.
// - With status append enabled each result carries the status word.
// - Index codes 0-7 are inputs, 8 supply, 9 regulator, 11 test pattern.
`timescale 1ns/100ps
`include "adc_regs_params.svh"

module adc_range_status_regs
   import adc_regs_pkg::*;
(
   input  wire logic         clk_sys,
   input  wire logic         rst_n,
   input  wire logic         hsel,
   input  wire logic [31:0]  haddr,
   input  wire logic [1:0]   htrans,
   input  wire logic         hwrite,
   input  wire logic [2:0]   hsize,
   input  wire logic [31:0]  hwdata,
   input  wire logic         hready,
   output logic              hreadyout,
   output logic [31:0]       hrdata,
   output logic              hresp,
   input  wire logic         conv_valid,
   input  wire logic [3:0]   conv_a_index,
   input  wire logic [3:0]   conv_b_index,
   input  wire logic [15:0]  conv_a_data,
   input  wire logic [15:0]  conv_b_data,
   output logic              result_valid,
   output logic [15:0]       result_a,
   output logic [15:0]       result_b,
   output logic [15:0]       result_status,
   output logic              result_status_valid,
   output logic [15:0]       a_span_code,
   output logic [15:0]       b_span_code,
   output logic [7:0]        a_span_extend,
   output logic [7:0]        b_span_extend,
   output logic [127:0]      a_full_scale_mv,
   output logic [127:0]      b_full_scale_mv
);

   localparam logic [15:0] RST_CFG  = `RST_CONFIG;
   localparam logic [15:0] RST_AL   = `RST_A_RANGE_LOW;
   localparam logic [15:0] RST_AH   = `RST_A_RANGE_HIGH;
   localparam logic [15:0] RST_BL   = `RST_B_RANGE_LOW;
   localparam logic [15:0] RST_BH   = `RST_B_RANGE_HIGH;
   localparam logic [15:0] RST_AOVR = `RST_A_OVERRANGE;
   localparam logic [15:0] RST_BOVR = `RST_B_OVERRANGE;

   reg_idx_t     reg_sel;
   logic         reg_wr;
   logic [15:0]  reg_wdata;
   logic [15:0]  reg_rdata;
   logic [15:0]  status_word;
   logic         wr_ok;

   logic         status_append_enable;
   logic         next_status_append_enable;
   logic [7:0]   a_range_low;
   logic [7:0]   next_a_range_low;
   logic [7:0]   a_range_high;
   logic [7:0]   next_a_range_high;
   logic [7:0]   b_range_low;
   logic [7:0]   next_b_range_low;
   logic [7:0]   b_range_high;
   logic [7:0]   next_b_range_high;
   logic [7:0]   a_overrange;
   logic [7:0]   next_a_overrange;
   logic [7:0]   b_overrange;
   logic [7:0]   next_b_overrange;
   logic [127:0] next_a_full_scale_mv;
   logic [127:0] next_b_full_scale_mv;

   // Read word: direction reads 0, select echoes the register, bit 8 zero
   function automatic logic [15:0] read_word(input reg_idx_t idx, input logic [7:0] fields);
      return {1'b0, idx, 1'b0, fields};
   endfunction : read_word

   function automatic logic [15:0] full_scale_mv(input logic [1:0] code, input logic extend);
      logic [15:0] base;
      case (span_code_e'(code))
         SPAN_2V5: base = `SPAN_2V5_MV;
         SPAN_5V:  base = `SPAN_5V_MV;
         default:  base = `SPAN_10V_MV;
      endcase
      return extend ? base + (base / `OVERRANGE_DIV) : base;
   endfunction : full_scale_mv

   ahb_reg_port u_bus (
      .clk_sys   (clk_sys),
      .rst_n     (rst_n),
      .hsel      (hsel),
      .haddr     (haddr),
      .htrans    (htrans),
      .hwrite    (hwrite),
      .hsize     (hsize),
      .hwdata    (hwdata),
      .hready    (hready),
      .hreadyout (hreadyout),
      .hrdata    (hrdata),
      .hresp     (hresp),
      .reg_sel   (reg_sel),
      .reg_wr    (reg_wr),
      .reg_wdata (reg_wdata),
      .reg_rdata (reg_rdata)
   );

   conv_status_unit u_status (
      .clk_sys              (clk_sys),
      .rst_n                (rst_n),
      .conv_valid           (conv_valid),
      .conv_a_index         (conv_a_index),
      .conv_b_index         (conv_b_index),
      .conv_a_data          (conv_a_data),
      .conv_b_data          (conv_b_data),
      .status_append_enable (status_append_enable),
      .status_word          (status_word),
      .result_valid         (result_valid),
      .result_a             (result_a),
      .result_b             (result_b),
      .result_status        (result_status),
      .result_status_valid  (result_status_valid)
   );

   // Readback
   always_comb begin
      case (reg_sel)
         `IDX_CONFIG:       reg_rdata = read_word(reg_sel, {6'h00, status_append_enable, 1'b0});
         `IDX_A_RANGE_LOW:  reg_rdata = read_word(reg_sel, a_range_low);
         `IDX_A_RANGE_HIGH: reg_rdata = read_word(reg_sel, a_range_high);
         `IDX_B_RANGE_LOW:  reg_rdata = read_word(reg_sel, b_range_low);
         `IDX_B_RANGE_HIGH: reg_rdata = read_word(reg_sel, b_range_high);
         `IDX_STATUS:       reg_rdata = status_word;
         `IDX_A_OVERRANGE:  reg_rdata = read_word(reg_sel, a_overrange);
         `IDX_B_OVERRANGE:  reg_rdata = read_word(reg_sel, b_overrange);
         default:           reg_rdata = 16'h0000;
      endcase
   end

   // A word whose direction or select disagrees with its address is dropped,
   // so a stray read-formatted word can never overwrite a span
   always_comb begin
      wr_ok = reg_wr && reg_wdata[`DIR_BIT] &&
              (reg_wdata[`SEL_HI:`SEL_LO] == reg_sel);
      next_status_append_enable = status_append_enable;
      next_a_range_low          = a_range_low;
      next_a_range_high         = a_range_high;
      next_b_range_low          = b_range_low;
      next_b_range_high         = b_range_high;
      next_a_overrange          = a_overrange;
      next_b_overrange          = b_overrange;
      if (wr_ok) begin
         case (reg_sel)
            `IDX_CONFIG:       next_status_append_enable = reg_wdata[`STATUS_APPEND_BIT];
            `IDX_A_RANGE_LOW:  next_a_range_low  = reg_wdata[`FIELD_HI:0];
            `IDX_A_RANGE_HIGH: next_a_range_high = reg_wdata[`FIELD_HI:0];
            `IDX_B_RANGE_LOW:  next_b_range_low  = reg_wdata[`FIELD_HI:0];
            `IDX_B_RANGE_HIGH: next_b_range_high = reg_wdata[`FIELD_HI:0];
            `IDX_A_OVERRANGE:  next_a_overrange  = reg_wdata[`FIELD_HI:0];
            `IDX_B_OVERRANGE:  next_b_overrange  = reg_wdata[`FIELD_HI:0];
            default: begin
            end
         endcase
      end
   end

   // Effective spans follow the register values one cycle later
   always_comb begin
      for (int n = 0; n < 4; n++) begin
         next_a_full_scale_mv[16*n +: 16]     = full_scale_mv(a_range_low[2*n +: 2],
                                                              a_overrange[n]);
         next_a_full_scale_mv[16*(n+4) +: 16] = full_scale_mv(a_range_high[2*n +: 2],
                                                              a_overrange[n+4]);
         next_b_full_scale_mv[16*n +: 16]     = full_scale_mv(b_range_low[2*n +: 2],
                                                              b_overrange[n]);
         next_b_full_scale_mv[16*(n+4) +: 16] = full_scale_mv(b_range_high[2*n +: 2],
                                                              b_overrange[n+4]);
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         status_append_enable <= RST_CFG[`STATUS_APPEND_BIT];
         a_range_low          <= RST_AL[`FIELD_HI:0];
         a_range_high         <= RST_AH[`FIELD_HI:0];
         b_range_low          <= RST_BL[`FIELD_HI:0];
         b_range_high         <= RST_BH[`FIELD_HI:0];
         a_overrange          <= RST_AOVR[`FIELD_HI:0];
         b_overrange          <= RST_BOVR[`FIELD_HI:0];
         a_full_scale_mv      <= {8{`SPAN_10V_MV}};
         b_full_scale_mv      <= {8{`SPAN_10V_MV}};
      end else begin
         status_append_enable <= next_status_append_enable;
         a_range_low          <= next_a_range_low;
         a_range_high         <= next_a_range_high;
         b_range_low          <= next_b_range_low;
         b_range_high         <= next_b_range_high;
         a_overrange          <= next_a_overrange;
         b_overrange          <= next_b_overrange;
         a_full_scale_mv      <= next_a_full_scale_mv;
         b_full_scale_mv      <= next_b_full_scale_mv;
      end
   end

   assign a_span_code   = {a_range_high, a_range_low};
   assign b_span_code   = {b_range_high, b_range_low};
   assign a_span_extend = a_overrange;
   assign b_span_extend = b_overrange;

endmodule : adc_range_status_regs

// ### rtl/ahb_reg_port.sv
// Purpose: AHB-Lite slave front end with one wait state per transfer
// Assumes: Single slave on the bus, so hready is our own hreadyout
// Notes:   Read data and ready come from flops; response is always OKAY
`timescale 1ns/100ps
`include "adc_regs_params.svh"

module ahb_reg_port
   import adc_regs_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        rst_n,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic [31:0]      hrdata,
   output logic             hresp,
   output reg_idx_t         reg_sel,
   output logic             reg_wr,
   output logic [15:0]      reg_wdata,
   input  wire logic [15:0] reg_rdata
);

   bus_state_e  state;
   bus_state_e  next_state;
   reg_idx_t    sel;
   reg_idx_t    next_sel;
   logic        wr_pend;
   logic        next_wr_pend;
   logic        ok;
   logic        next_ok;
   logic        next_hreadyout;
   logic [31:0] next_hrdata;

   always_comb begin
      next_state     = state;
      next_sel       = sel;
      next_wr_pend   = wr_pend;
      next_ok        = ok;
      next_hreadyout = hreadyout;
      next_hrdata    = hrdata;
      reg_wr         = 1'b0;
      case (state)
         BUS_IDLE: begin
            if (hsel && htrans[1] && hready) begin
               next_sel       = haddr[7:`BUS_ADDR_LSB];
               next_wr_pend   = hwrite;
               // Only aligned whole words inside the bank are honoured
               next_ok        = (haddr[31:8] == `BUS_ADDR_HI_ZERO) &&
                                (haddr[1:0] == 2'h0) && (hsize == `BUS_SIZE_WORD);
               next_hreadyout = 1'b0;
               next_state     = BUS_WAIT;
            end
         end
         BUS_WAIT: begin
            // hwdata is valid in this data-phase cycle
            reg_wr         = wr_pend && ok;
            next_hrdata    = (ok && !wr_pend) ? {16'h0000, reg_rdata} : 32'h00000000;
            next_hreadyout = 1'b1;
            next_state     = BUS_IDLE;
         end
         default: begin
            next_hreadyout = 1'b1;
            next_state     = BUS_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state     <= BUS_IDLE;
         sel       <= 6'h00;
         wr_pend   <= 1'b0;
         ok        <= 1'b0;
         hreadyout <= 1'b1;
         hrdata    <= 32'h00000000;
         hresp     <= 1'b0;
      end else begin
         state     <= next_state;
         sel       <= next_sel;
         wr_pend   <= next_wr_pend;
         ok        <= next_ok;
         hreadyout <= next_hreadyout;
         hrdata    <= next_hrdata;
         hresp     <= 1'b0;
      end
   end

   assign reg_sel   = sel;
   assign reg_wdata = hwdata[15:0];

endmodule : ahb_reg_port

// ### rtl/conv_status_unit.sv
// Purpose: Tracks last converted channels, output-data CRC and result framing
// Assumes: conv_valid is a one-cycle pulse per simultaneous conversion pair
// Notes:   Result appears one cycle after conv_valid
`timescale 1ns/100ps
`include "adc_regs_params.svh"

module conv_status_unit
   import adc_regs_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        rst_n,
   input  wire logic        conv_valid,
   input  wire logic [3:0]  conv_a_index,
   input  wire logic [3:0]  conv_b_index,
   input  wire logic [15:0] conv_a_data,
   input  wire logic [15:0] conv_b_data,
   input  wire logic        status_append_enable,
   output logic [15:0]      status_word,
   output logic             result_valid,
   output logic [15:0]      result_a,
   output logic [15:0]      result_b,
   output logic [15:0]      result_status,
   output logic             result_status_valid
);

   logic [15:0] a_word;
   logic [15:0] b_word;
   logic [7:0]  crc_new;
   logic [15:0] next_status_word;
   logic        next_result_valid;
   logic [15:0] next_result_a;
   logic [15:0] next_result_b;
   logic [15:0] next_result_status;
   logic        next_result_status_valid;

   function automatic logic [7:0] crc8_word(input logic [7:0] crc_in, input logic [15:0] data);
      logic [7:0] c;
      c = crc_in;
      for (int i = 15; i >= 0; i--) begin
         if (c[7] ^ data[i]) begin
            c = {c[6:0], 1'b0} ^ `CRC8_POLY;
         end else begin
            c = {c[6:0], 1'b0};
         end
      end
      return c;
   endfunction : crc8_word

   always_comb begin
      a_word = (conv_a_index == CH_TEST_PATTERN) ? `TEST_PATTERN_A : conv_a_data;
      b_word = (conv_b_index == CH_TEST_PATTERN) ? `TEST_PATTERN_B : conv_b_data;
      crc_new = crc8_word(crc8_word(`CRC8_INIT, a_word), b_word);
      next_status_word         = status_word;
      next_result_valid        = 1'b0;
      next_result_a            = result_a;
      next_result_b            = result_b;
      next_result_status       = result_status;
      next_result_status_valid = 1'b0;
      if (conv_valid) begin
         next_status_word  = {conv_a_index, conv_b_index, crc_new};
         next_result_valid = 1'b1;
         next_result_a     = a_word;
         next_result_b     = b_word;
         next_result_status       = status_append_enable ? next_status_word : 16'h0000;
         next_result_status_valid = status_append_enable;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         status_word         <= `RST_STATUS;
         result_valid        <= 1'b0;
         result_a            <= 16'h0000;
         result_b            <= 16'h0000;
         result_status       <= 16'h0000;
         result_status_valid <= 1'b0;
      end else begin
         status_word         <= next_status_word;
         result_valid        <= next_result_valid;
         result_a            <= next_result_a;
         result_b            <= next_result_b;
         result_status       <= next_result_status;
         result_status_valid <= next_result_status_valid;
      end
   end

endmodule : conv_status_unit

// ### tb/adc_range_status_chk.sv
// Purpose: Assertions on bus timing, results and spans of the range bank
// Assumes: One clock domain, rst_n active low
// Notes:   Full-scale checks wait until span and extend settle
`timescale 1ns/100ps
module adc_range_status_chk (
   input wire logic         clk_sys,
   input wire logic         rst_n,
   input wire logic         hsel,
   input wire logic [1:0]   htrans,
   input wire logic         hready,
   input wire logic         hreadyout,
   input wire logic         hresp,
   input wire logic         conv_valid,
   input wire logic [3:0]   conv_a_index,
   input wire logic [3:0]   conv_b_index,
   input wire logic         result_valid,
   input wire logic [15:0]  result_a,
   input wire logic [15:0]  result_status,
   input wire logic         result_status_valid,
   input wire logic [15:0]  a_span_code,
   input wire logic [15:0]  b_span_code,
   input wire logic [7:0]   a_span_extend,
   input wire logic [7:0]   b_span_extend,
   input wire logic [127:0] a_full_scale_mv,
   input wire logic [127:0] b_full_scale_mv
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   function automatic logic [15:0] fs(input logic [1:0] c, input logic x);
      logic [15:0] b;
      b = (c == 2'h1) ? 16'h09C4 : (c == 2'h2) ? 16'h1388 : 16'h2710;
      return x ? b + b / 16'h0005 : b;
   endfunction : fs
   sequence taken;
      hsel && htrans[1] && hready && hreadyout;
   endsequence
   sequence one_wait;
      !hreadyout ##1 hreadyout;
   endsequence
   chk_one_wait: assert property (taken |=> one_wait)
      else $error("wait state not one cycle");
   chk_resp_okay: assert property (hresp == 1'h0)
      else $error("error response seen");
   chk_result_next: assert property (conv_valid |=> result_valid)
      else $error("result pulse missing");
   chk_status_ids: assert property (result_status_valid |->
      result_status[15:8] == {$past(conv_a_index), $past(conv_b_index)})
      else $error("status channel index wrong");
   chk_status_pair: assert property (result_status_valid |-> result_valid)
      else $error("status valid without result");
   chk_no_append: assert property (
      result_valid && !result_status_valid |-> result_status == 16'h0000)
      else $error("status present while append off");
   chk_pattern_a: assert property (conv_valid && conv_a_index == 4'hB |=>
      result_a == 16'hAAAA)
      else $error("test pattern missing");
   chk_b_scale: assert property ($stable(b_span_code) && $stable(b_span_extend) |->
      b_full_scale_mv[15:0] == fs(b_span_code[1:0], b_span_extend[0]))
      else $error("b channel 0 full scale wrong");
   chk_a_scale: assert property ($stable(a_span_code) && $stable(a_span_extend) |->
      a_full_scale_mv[127:112] == fs(a_span_code[15:14], a_span_extend[7]))
      else $error("a channel 7 full scale wrong");
endmodule : adc_range_status_chk

bind adc_range_status_regs adc_range_status_chk i_adc_range_status_chk (.*);

// ### tb/ahb_host_model.sv
// Purpose: AHB-Lite host issuing single word transfers
// Assumes: hready is the slave's own hreadyout
// Notes:   Write data is inverted once its phase ends, never left stale
`timescale 1ns/100ps
module ahb_host_model (
   input  wire logic        clk_sys,
   input  wire logic        hready,
   input  wire logic [31:0] hrdata,
   output logic             hsel,
   output logic [31:0]      haddr,
   output logic [1:0]       htrans,
   output logic             hwrite,
   output logic [2:0]       hsize,
   output logic [31:0]      hwdata
);
   initial begin
      hsel = 1'h0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'h0;
      hsize = 3'h2;
      hwdata = 32'h0;
   end
   function automatic logic [15:0] word(input logic w, input logic [5:0] i, input logic [8:0] lo);
      return {w, i, lo};
   endfunction : word
   task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
      @(posedge clk_sys);
      hsel <= 1'h1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= w;
      @(posedge clk_sys);
      while (!hready) @(posedge clk_sys);
      hsel <= 1'h0;
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge clk_sys);
      while (!hready) @(posedge clk_sys);
      rd = hrdata;
      hwdata <= ~wd;
   endtask : xfer
endmodule : ahb_host_model

// ### tb/tb_top.sv
// Purpose: Self-checking bench for the range/status bank
// Assumes: Host model drives the bus, bench drives conversions
// Notes:   Reads and results compared by a monitor against queues
`timescale 1ns/100ps
module tb_top;
   logic         clk_sys, rst_n, hsel, hwrite, hreadyout, hresp, conv_valid, rd_ph;
   logic         result_valid, result_status_valid;
   logic [31:0]  haddr, hwdata, hrdata, lfsr, rd;
   logic [1:0]   htrans;
   logic [2:0]   hsize;
   logic [3:0]   conv_a_index, conv_b_index;
   logic [15:0]  conv_a_data, conv_b_data, result_a, result_b, result_status, last_st;
   logic [15:0]  a_span_code, b_span_code;
   logic [7:0]   a_span_extend, b_span_extend, f;
   logic [127:0] a_full_scale_mv, b_full_scale_mv;
   logic [5:0]   i;
   logic [7:0]   fld [0:15];
   logic [48:0]  exp_res [$];
   logic [31:0]  exp_rd [$];
   logic [5:0]   idx_t [0:8] = '{6'h02, 6'h04, 6'h05, 6'h06, 6'h07, 6'h08, 6'h0A, 6'h0B, 6'h03};
   logic [15:0]  rst_t [0:8] = '{16'h0400, 16'h08FF, 16'h0AFF, 16'h0CFF, 16'h0EFF,
                                 16'h0000, 16'h1400, 16'h1600, 16'h0000};
   logic [3:0]   cd [0:10] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hB};
   int           errors, checked, cycles;

   adc_range_status_regs i_adc_range_status_regs (.*, .hready(hreadyout));
   ahb_host_model i_ahb_host_model (.*, .hready(hreadyout));

   function automatic logic [31:0] nxt(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction : nxt
   function automatic logic [15:0] fs(input logic [1:0] c, input logic x);
      logic [15:0] b;
      b = (c == 2'h1) ? 16'h09C4 : (c == 2'h2) ? 16'h1388 : 16'h2710;
      return x ? b + b / 16'h0005 : b;
   endfunction : fs
   task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
      checked++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic give_verdict;
      if (errors == 0 && checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : give_verdict
   task automatic rdw(input logic [31:0] a, input logic [15:0] e);
      exp_rd.push_back({16'h0, e});
      i_ahb_host_model.xfer(1'h0, a, 32'h0, rd);
   endtask : rdw
   task automatic wrw(input logic [5:0] x, input logic [15:0] w);
      i_ahb_host_model.xfer(1'h1, {24'h0, x, 2'h0}, {16'h0, w}, rd);
   endtask : wrw
   // Expected pair, CRC over a then b, msb first
   task automatic conv(input logic [3:0] ai, input logic [3:0] bi, input logic app);
      logic [31:0] d;
      logic [7:0]  c;
      lfsr = nxt(lfsr);
      d = {(ai == 4'hB) ? 16'hAAAA : lfsr[15:0], (bi == 4'hB) ? 16'h5555 : lfsr[31:16]};
      c = 8'h00;
      for (int k = 31; k >= 0; k--) c = {c[6:0], 1'h0} ^ ((c[7] ^ d[k]) ? 8'h07 : 8'h00);
      last_st = {ai, bi, c};
      exp_res.push_back({d, app ? last_st : 16'h0000, app});
      conv_valid <= 1'h1;
      conv_a_index <= ai;
      conv_b_index <= bi;
      conv_a_data <= lfsr[15:0];
      conv_b_data <= lfsr[31:16];
      @(posedge clk_sys);
   endtask : conv

   initial begin
      clk_sys = 1'h0;
      forever #20 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 5000) begin
         errors++;
         give_verdict();
      end
   end
   always @(posedge clk_sys) begin
      if (rd_ph && hreadyout) check("hrdata", hrdata, exp_rd.pop_front());
      if (hreadyout) rd_ph <= hsel && htrans[1] && !hwrite;
      if (result_valid) check("result", {result_a, result_b, result_status,
                              result_status_valid}, exp_res.pop_front());
   end

   initial begin
      rst_n = 1'h0;
      conv_valid = 1'h0;
      conv_a_index = 4'h0;
      conv_b_index = 4'h0;
      conv_a_data = 16'h0;
      conv_b_data = 16'h0;
      lfsr = 32'h0557;
      repeat (10) @(posedge clk_sys);
      rst_n <= 1'h1;
      for (int k = 0; k < 9; k++) rdw({24'h0, idx_t[k], 2'h0}, rst_t[k]);
      for (int k = 1; k < 8; k++) begin
         i = idx_t[k];
         lfsr = nxt(lfsr);
         f = lfsr[7:0];
         fld[i] = f;
         if (i != 6'h08) begin
            wrw(i, i_ahb_host_model.word(1'h1, i, {1'h1, f}));
            wrw(i, i_ahb_host_model.word(1'h0, i, {1'h0, ~f}));
            wrw(i, i_ahb_host_model.word(1'h1, i ^ 6'h01, {1'h0, ~f}));
            rdw({24'h0, i, 2'h0}, {1'h0, i, 1'h0, f});
         end
      end
      check("a_span", a_span_code, {fld[5], fld[4]});
      check("b_span", b_span_code, {fld[7], fld[6]});
      check("a_ext", a_span_extend, fld[10]);
      check("b_ext", b_span_extend, fld[11]);
      for (int n = 0; n < 8; n++) begin
         check("a_fs", a_full_scale_mv[16*n+:16],
               fs(fld[4+n/4][2*(n%4)+:2], fld[10][n]));
         check("b_fs", b_full_scale_mv[16*n+:16],
               fs(fld[6+n/4][2*(n%4)+:2], fld[11][n]));
      end
      wrw(6'h08, 16'h91FF);
      rdw(32'h20, 16'h0000);
      rdw(32'h100, 16'h0000);
      wrw(6'h02, 16'h8402);
      for (int k = 0; k < 11; k++) conv(cd[k], cd[(k + 4) % 11], 1'h1);
      conv_valid <= 1'h0;
      rdw(32'h20, last_st);
      wrw(6'h02, 16'h8400);
      conv(4'hB, 4'hB, 1'h0);
      conv(4'h3, 4'h8, 1'h0);
      conv_valid <= 1'h0;
      repeat (2) @(posedge clk_sys);
      check("pending", exp_res.size(), 64'h0);
      give_verdict();
   end
endmodule : tb_top
